// ### core/psi_interlock.v
// Pipeline stall and interlock control between decode and execute.
// Assumes decode presents one instruction descriptor with dec_valid,
// holds it while dec_hold is high, and external bus wait counts are
// supplied by the bus interface in core clock cycles.
// Decode may already show the next descriptor while bubbles run, so
// a stalled instruction's hazard fields are captured when it is taken.
`timescale 1ns/100ps
`include "psi_consts.vh"

// What this block does
// (RL1) External data access lengthens execution by its programmed wait states.
// (RL2) External instruction fetch stalls for the bus wait control count.
// (RL3) Move sourcing accumulator after arithmetic write of it delays one cycle.
// (RL4) Move sourcing accumulator after move write of it delays one cycle.
// (RL5) Status read after arithmetic within two: move stalls two, bit test one.
// (RL6) Conditional transfer then explicit pointer source delays one cycle.
// (RL7) Address use hazards against pointer, offset, modifier writes within three cycles.
// (RL8) Adjacent writer inserts three bubbles before the using instruction.
// (RL9) One instruction between inserts two bubbles.
// (RL10) Two instructions between inserts one bubble.
// (RL11) Distance counted in clock cycles when the user enters decode.
// (RL12) Inserted bubbles count toward distance for later instructions.
// (RL13) Displacement moves take two cycles short, three long.
// (RL14) Peripheral moves: program six, data two, plus one per option.
// (RL15) Bit test jump subroutine takes four, plus one for pre-update.
// (RL16) Control register move takes one plus one per option.
// (RL17) Base counts assume ideal case; options add their cycles, except for displacement moves and PSI_CLS_OTHER, which add none.
// (RL18) Decode holds its instruction while bubbles go to execute.
// (RL19) Concurrent stalls take the largest delay, separate resources add.
module psi_interlock #(
  parameter WAIT_W = `PSI_WAIT_W,
  parameter NREG   = 8
) (
  // Clock and reset
  input  wire                  core_clk,
  input  wire                  rstn,
  // Decode stage descriptor
  input  wire                  dec_valid,
  input  wire [`PSI_CLS_W-1:0] dec_class,
  input  wire [3:0]            dec_generic_t,
  input  wire                  dec_long_disp,
  input  wire                  dec_pre_update,
  input  wire                  dec_long_abs,
  input  wire                  dec_long_imm,
  input  wire                  dec_is_arith,
  input  wire                  dec_is_cond_xfer,
  input  wire [1:0]            dec_move_src_acc,
  input  wire [1:0]            dec_move_dst_acc,
  input  wire [1:0]            dec_arith_dst_acc,
  input  wire                  dec_sr_read_move,
  input  wire                  dec_sr_read_bit,
  input  wire [NREG-1:0]       dec_ptr_src,
  input  wire [NREG-1:0]       dec_agu_use,
  input  wire [NREG-1:0]       dec_agu_wr,
  // External bus timing
  input  wire                  ext_data_acc,
  input  wire [WAIT_W-1:0]     ext_data_waits,
  input  wire                  ext_fetch,
  input  wire [WAIT_W-1:0]     bus_wait_control_reg,
  // Execute stage side
  output reg                   dec_hold,
  output reg                   exe_issue,
  output reg                   exe_bubble,
  output reg  [3:0]            exe_base_cycles,
  output reg  [5:0]            exe_stall_cycles
);

  localparam CW = 6;

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Count of addressing options present, each adds one cycle
  function [3:0] opt_add;
    input pre;
    input lab;
    input lim;
    begin
      opt_add = (pre ? `PSI_ADD_OPT : 4'h0) + (lab ? `PSI_ADD_OPT : 4'h0)
              + (lim ? `PSI_ADD_OPT : 4'h0);
    end
  endfunction

  // Larger of two stall counts
  function [5:0] max6;
    input [5:0] a;
    input [5:0] b;
    begin
      max6 = (a > b) ? a : b;
    end
  endfunction

  // ****************************************************************
  // Hazard history
  // ****************************************************************

  // Per-set age in cycles since last pointer/offset/modifier write
  reg  [1:0]      agu_age_r [0:NREG-1];
  reg  [NREG-1:0] agu_live_r;
  reg  [1:0]      acc_arith_r;
  reg  [1:0]      acc_move_r;
  reg  [1:0]      arith_hist_r;
  reg             cond_prev_r;

  wire            cnt_busy;
  wire [CW-1:0]   cnt_remain;
  wire            accept;
  reg  [5:0]      stall_nxt;
  reg  [5:0]      agu_stall;
  reg  [5:0]      dalu_stall;
  reg  [5:0]      bus_stall;
  reg  [3:0]      base_nxt;
  integer         i;
  integer         j;

  // Fields of a stalled instruction, held for its issue edge
  reg             held_arith_r;
  reg  [1:0]      held_arith_acc_r;
  reg  [1:0]      held_move_acc_r;
  reg             held_cond_r;
  reg  [NREG-1:0] held_agu_wr_r;
  wire            issue_now;
  wire            issue_held;

  // A new instruction is taken when no bubbles remain
  assign accept = dec_valid && !cnt_busy;

  // ****************************************************************
  // Issue strobes
  // ****************************************************************

  // Issue at once when taken with no stall, or on the last bubble;
  // history is written at issue so bubbles count toward distance
  assign issue_now  = accept && (stall_nxt == 6'h00);
  assign issue_held = cnt_busy && (cnt_remain == 6'h01);

  // ****************************************************************
  // Stall calculation
  // ****************************************************************

  // Address generation distance grading
  always @* begin
    agu_stall = 6'h00;
    for (i = 0; i < NREG; i = i + 1) begin
      if (dec_agu_use[i] && agu_live_r[i]) begin // see (RL7) (RL11)
        case (agu_age_r[i])
          2'd0: agu_stall = max6(agu_stall, {2'b00, `PSI_AGU_ADJ}); // see (RL8)
          2'd1: agu_stall = max6(agu_stall,
                                 {2'b00, `PSI_AGU_ONE_GAP}); // see (RL9)
          default: agu_stall = max6(agu_stall,
                                 {2'b00, `PSI_AGU_TWO_GAP}); // see (RL10)
        endcase
      end
    end
  end

  // Data ALU and conditional transfer interlocks, largest wins
  always @* begin
    dalu_stall = 6'h00;
    if ((dec_move_src_acc & acc_arith_r) != 2'b00) begin
      dalu_stall = max6(dalu_stall, {2'b00, `PSI_ARITH_STALL}); // see (RL3)
    end
    if ((dec_move_src_acc & acc_move_r) != 2'b00) begin
      dalu_stall = max6(dalu_stall, {2'b00, `PSI_XFER_STALL}); // see (RL4)
    end
    if (arith_hist_r != 2'b00) begin
      if (dec_sr_read_move) begin
        dalu_stall = max6(dalu_stall, {2'b00, `PSI_STAT_MOVE}); // see (RL5)
      end else if (dec_sr_read_bit) begin
        dalu_stall = max6(dalu_stall, {2'b00, `PSI_STAT_BIT}); // see (RL5)
      end
    end
    if (cond_prev_r && (dec_ptr_src != {NREG{1'b0}})) begin
      dalu_stall = max6(dalu_stall, {2'b00, `PSI_COND_STALL}); // see (RL6)
    end
  end

  // External bus waits add since they use a separate resource
  always @* begin
    bus_stall = 6'h00;
    if (ext_data_acc) begin
      bus_stall = bus_stall + {{(6-WAIT_W){1'b0}}, ext_data_waits}; // see (RL1)
    end
    if (ext_fetch) begin
      bus_stall = bus_stall
                + {{(6-WAIT_W){1'b0}}, bus_wait_control_reg}; // see (RL2)
    end
  end

  // Pipeline interlocks share the pipeline: take the max; bus adds
  always @* begin
    stall_nxt = max6(agu_stall, dalu_stall) + bus_stall; // see (RL19)
  end

  // Base cycle count by class and addressing options
  always @* begin
    case (dec_class)
      `PSI_CLS_DISP_MOVE: base_nxt = dec_long_disp ? `PSI_T_DISP_LONG
                                                   : `PSI_T_DISP_SHORT; // see (RL13)
      `PSI_CLS_PERI_PMEM: base_nxt = `PSI_T_PERI_PMEM
                        + opt_add(dec_pre_update, dec_long_abs, 1'b0); // see (RL14)
      `PSI_CLS_PERI_DMEM: base_nxt = `PSI_T_PERI_DMEM
                        + opt_add(dec_pre_update, dec_long_abs, 1'b0); // see (RL14)
      `PSI_CLS_BIT_JSR:   base_nxt = `PSI_T_BIT_JSR
                        + opt_add(dec_pre_update, 1'b0, 1'b0); // see (RL15)
      `PSI_CLS_CTRL_MOVE: base_nxt = `PSI_T_CTRL_MOVE
                        + opt_add(dec_pre_update, dec_long_abs,
                                  dec_long_imm); // see (RL16)
      `PSI_CLS_GENERIC:   base_nxt = dec_generic_t
                        + opt_add(dec_pre_update, dec_long_abs,
                                  dec_long_imm); // see (RL17)
      default:            base_nxt = dec_generic_t;
    endcase
  end

  // ****************************************************************
  // Bubble counter
  // ****************************************************************

  // Loaded with the stall count; nonzero means decode is held
  psi_bubble_cnt #(
    .CW (CW)
  ) u_cnt (
    .core_clk (core_clk),
    .rstn     (rstn),
    .load     (accept && (stall_nxt != 6'h00)),
    .load_val (stall_nxt),
    .busy     (cnt_busy),
    .remain   (cnt_remain)
  );

  // ****************************************************************
  // Held descriptor
  // ****************************************************************

  // Capture at the taking edge; decode may move on during bubbles,
  // and reading its live fields at issue would record the wrong one
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      held_arith_r     <= 1'b0;
      held_arith_acc_r <= 2'b00;
      held_move_acc_r  <= 2'b00;
      held_cond_r      <= 1'b0;
      held_agu_wr_r    <= {NREG{1'b0}};
    end else if (accept) begin
      held_arith_r     <= dec_is_arith;
      held_arith_acc_r <= dec_arith_dst_acc;
      held_move_acc_r  <= dec_move_dst_acc;
      held_cond_r      <= dec_is_cond_xfer;
      held_agu_wr_r    <= dec_agu_wr; // see (RL18)
    end
  end

  // ****************************************************************
  // History update
  // ****************************************************************

  // Ages advance every clock, bubbles included; a stalled writer
  // starts its age on its own issue edge
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (j = 0; j < NREG; j = j + 1) begin
        agu_age_r[j] <= 2'd0;
      end
      agu_live_r <= {NREG{1'b0}};
    end else begin
      for (j = 0; j < NREG; j = j + 1) begin
        if ((issue_now && dec_agu_wr[j])
            || (issue_held && held_agu_wr_r[j])) begin // see (RL7)
          agu_age_r[j]  <= 2'd0;
          agu_live_r[j] <= 1'b1;
        end else if (agu_live_r[j]) begin
          if (agu_age_r[j] == 2'd2) begin // see (RL12)
            agu_live_r[j] <= 1'b0;
          end else begin
            agu_age_r[j] <= agu_age_r[j] + 2'd1; // see (RL11)
          end
        end
      end
    end
  end

  // Previous-instruction flags, updated when an instruction executes
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      acc_arith_r  <= 2'b00;
      acc_move_r   <= 2'b00;
      arith_hist_r <= 2'b00;
      cond_prev_r  <= 1'b0;
    end else if (issue_now) begin
      acc_arith_r  <= dec_is_arith ? dec_arith_dst_acc : 2'b00;
      acc_move_r   <= dec_move_dst_acc;
      arith_hist_r <= {arith_hist_r[0], dec_is_arith};
      cond_prev_r  <= dec_is_cond_xfer;
    end else if (issue_held) begin
      // Stalled instruction: use the fields captured when taken
      acc_arith_r  <= held_arith_r ? held_arith_acc_r : 2'b00;
      acc_move_r   <= held_move_acc_r;
      arith_hist_r <= {arith_hist_r[0], held_arith_r};
      cond_prev_r  <= held_cond_r;
    end
  end

  // ****************************************************************
  // Execute stage outputs
  // ****************************************************************

  // Held instruction issues on the last bubble's following cycle
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dec_hold         <= 1'b0;
      exe_issue        <= 1'b0;
      exe_bubble       <= 1'b0;
      exe_base_cycles  <= 4'h0;
      exe_stall_cycles <= 6'h00;
    end else begin
      dec_hold   <= (accept && stall_nxt != 6'h00)
                 || (cnt_busy && cnt_remain != 6'h01); // see (RL18)
      exe_bubble <= (accept && stall_nxt != 6'h00)
                 || (cnt_busy && cnt_remain != 6'h01); // see (RL18)
      exe_issue  <= (accept && stall_nxt == 6'h00)
                 || (cnt_busy && cnt_remain == 6'h01);
      if (accept) begin
        exe_base_cycles  <= base_nxt;
        exe_stall_cycles <= stall_nxt;
      end
    end
  end

endmodule

// ### core/psi_consts.vh
// Constants for the pipeline stall and interlock control block.
// Assumes inclusion by bare name from core/ design files.
`ifndef PSI_CONSTS_VH
`define PSI_CONSTS_VH

// ****************************************************************
// Instruction class codes from decode
// ****************************************************************
`define PSI_CLS_W          4
`define PSI_CLS_OTHER      4'h0
`define PSI_CLS_DISP_MOVE  4'h1
`define PSI_CLS_PERI_PMEM  4'h2
`define PSI_CLS_PERI_DMEM  4'h3
`define PSI_CLS_BIT_JSR    4'h4
`define PSI_CLS_CTRL_MOVE  4'h5
`define PSI_CLS_GENERIC    4'h6

// ****************************************************************
// Base cycle counts
// ****************************************************************
`define PSI_T_DISP_SHORT   4'h2
`define PSI_T_DISP_LONG    4'h3
`define PSI_T_PERI_PMEM    4'h6
`define PSI_T_PERI_DMEM    4'h2
`define PSI_T_BIT_JSR      4'h4
`define PSI_T_CTRL_MOVE    4'h1
`define PSI_ADD_OPT        4'h1

// ****************************************************************
// Interlock stall counts
// ****************************************************************
`define PSI_ARITH_STALL    4'h1
`define PSI_XFER_STALL     4'h1
`define PSI_STAT_MOVE      4'h2
`define PSI_STAT_BIT       4'h1
`define PSI_COND_STALL     4'h1
`define PSI_AGU_ADJ        4'h3
`define PSI_AGU_ONE_GAP    4'h2
`define PSI_AGU_TWO_GAP    4'h1
`define PSI_AGU_WINDOW     3

// ****************************************************************
// Field widths
// ****************************************************************
`define PSI_CNT_W          4
`define PSI_WAIT_W         4

`endif

// ### core/psi_bubble_cnt.v
// Stall counter that issues no-operation bubbles while held.
// Assumes a single core clock and an asynchronous active-low reset.
`timescale 1ns/100ps

module psi_bubble_cnt #(
  parameter CW = 6
) (
  // Clock and reset
  input  wire          core_clk,
  input  wire          rstn,
  // Load side
  input  wire          load,
  input  wire [CW-1:0] load_val,
  // Status
  output wire          busy,
  output wire [CW-1:0] remain
);

  reg [CW-1:0] cnt_r;
  reg [CW-1:0] cnt_nxt;

  // Next count: load a new stall or count down
  always @* begin
    cnt_nxt = cnt_r;
    if (load) begin
      cnt_nxt = load_val;
    end else if (cnt_r != {CW{1'b0}}) begin
      cnt_nxt = cnt_r - {{(CW-1){1'b0}}, 1'b1};
    end
  end

  // Counter register
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= {CW{1'b0}};
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign busy   = (cnt_r != {CW{1'b0}});
  assign remain = cnt_r;

endmodule

// ### tb/psi_interlock_sva.sv
// Assertion checker for the interlock block, bound to its ports.
// Assumes psi_consts.vh is on the include path.
`timescale 1ns/100ps
`include "psi_consts.vh"

module psi_interlock_chk #(
  parameter WAIT_W = 4,
  parameter NREG   = 8
) (
  // Clock and reset
  input wire                  core_clk,
  input wire                  rstn,
  // Decode side
  input wire                  dec_valid,
  input wire [`PSI_CLS_W-1:0] dec_class,
  input wire                  dec_long_disp,
  input wire                  dec_pre_update,
  input wire                  dec_long_abs,
  input wire                  dec_long_imm,
  input wire [NREG-1:0]       dec_agu_use,
  input wire [NREG-1:0]       dec_agu_wr,
  input wire                  ext_data_acc,
  input wire [WAIT_W-1:0]     ext_data_waits,
  input wire                  ext_fetch,
  input wire [WAIT_W-1:0]     bus_wait_control_reg,
  // Execute side
  input wire                  dec_hold,
  input wire                  exe_issue,
  input wire                  exe_bubble,
  input wire [3:0]            exe_base_cycles,
  input wire [5:0]            exe_stall_cycles
);
  logic       acc;
  logic [5:0] wsum;
  logic [5:0] bub_r;

  // Accept strobe and bus wait total of the offered descriptor
  assign acc  = dec_valid && !dec_hold;
  assign wsum = (ext_data_acc ? 6'(ext_data_waits) : 6'h00)
              + (ext_fetch ? 6'(bus_wait_control_reg) : 6'h00);

  // Bubbles seen since the last issue
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bub_r <= 6'h00;
    end else if (exe_issue) begin
      bub_r <= 6'h00;
    end else if (exe_bubble) begin
      bub_r <= bub_r + 6'h01;
    end
  end

  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // Writer taken, then a user of the same set taken at the next edge
  sequence s_wr;
    acc && |dec_agu_wr;
  endsequence
  sequence s_use;
    acc && |(dec_agu_use & $past(dec_agu_wr));
  endsequence

  // ************
  // Assertions
  // ************
  a_hold_bubble:
    assert property (dec_hold == exe_bubble)
    else $error("hold and bubble differ");
  a_bubble_close:
    assert property (exe_bubble |=> exe_bubble || exe_issue)
    else $error("bubble run not ended by issue");
  a_bubble_count:
    assert property (exe_issue |-> bub_r == exe_stall_cycles)
    else $error("bubble count differs from stall");
  a_idle_quiet:
    assert property (!dec_valid && !dec_hold |=> !exe_issue && !exe_bubble)
    else $error("activity without a descriptor");
  a_wait_sum:
    assert property (acc |=> exe_stall_cycles >= $past(wsum))
    else $error("bus waits not added");
  a_disp_base:
    assert property (acc && dec_class == `PSI_CLS_DISP_MOVE |=>
      exe_base_cycles == ($past(dec_long_disp) ? 4'h3 : 4'h2))
    else $error("displacement base wrong");
  a_ctrl_base:
    assert property (acc && dec_class == `PSI_CLS_CTRL_MOVE |=>
      exe_base_cycles == 4'h1 + $past(dec_pre_update)
      + $past(dec_long_abs) + $past(dec_long_imm))
    else $error("control move base wrong");
  a_agu_adj:
    assert property (s_wr ##1 s_use |=> exe_stall_cycles >= 6'h03)
    else $error("adjacent address hazard short");
endmodule

bind psi_interlock psi_interlock_chk #(
  .WAIT_W(WAIT_W),
  .NREG(NREG)
) u_chk (.*);

// ### tb/psi_dec_model.sv
// Decode stage model presenting queued descriptors to the block.
// Assumes the bench pushes each sequence into q in zero time.
`timescale 1ns/100ps

module psi_dec_model (
  // Clock and reset
  input  wire         core_clk,
  input  wire         rstn,
  // Interlock side
  input  wire         dec_hold,
  output logic [56:0] dsc
);
  logic [56:0] q[$];
  logic        tk;

  // Notes a descriptor taken at the sampling edge
  always @(posedge core_clk) begin
    tk <= dsc[56] & ~dec_hold;
  end

  // Holds each descriptor until taken; idle fields keep changing
  always @(negedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dsc <= '0;
    end else if (!dsc[56] || tk) begin
      if (q.size() != 0) begin
        dsc <= q.pop_front();
      end else begin
        dsc <= {1'b0, ~dsc[55:0]};
      end
    end
  end
endmodule

// ### tb/tb_pipeline_stall_interlock_control.sv
// Self-checking bench for the interlock block.
// Assumes the decode model and the checker are compiled first.
`timescale 1ns/100ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin err_total++; \
  $display("ERROR %s exp %0h got %0h", n, e, a); end end
`define FLD {v, c, g, ld, pu, la, li, ar, cx, ms, md, ad, sm, sb, ps, au, \
  aw, xa, xw, xf, bw}
`define NEU {1'b1, 4'h6, 4'h1, 48'h0}

module tb_pipeline_stall_interlock_control;
  logic core_clk, rstn, dec_valid, dec_long_disp, dec_pre_update;
  logic dec_long_abs, dec_long_imm, dec_is_arith, dec_is_cond_xfer;
  logic dec_sr_read_move, dec_sr_read_bit, ext_data_acc, ext_fetch;
  logic [3:0] dec_class, dec_generic_t, ext_data_waits;
  logic [3:0] bus_wait_control_reg;
  logic [1:0] dec_move_src_acc, dec_move_dst_acc, dec_arith_dst_acc;
  logic [7:0] dec_ptr_src, dec_agu_use, dec_agu_wr;
  wire        dec_hold, exe_issue, exe_bubble;
  wire [3:0]  exe_base_cycles;
  wire [5:0]  exe_stall_cycles;
  wire [56:0] dsc;
  logic       v, ld, pu, la, li, ar, cx, sm, sb, xa, xf, pa, pa2, pcx;
  logic [3:0] c, g, xw, bw;
  logic [1:0] ms, md, ad, pad, pmd;
  logic [7:0] ps, au, aw;
  logic [9:0] exp_q[$];
  int         err_total, checked, cyc, nb, now, tw[8];
  logic [9:0] alu_t[21] = '{10'h100, 10'h040, 10'h100, 10'h080, 10'h020,
    10'h0C0, 10'h200, 10'h008, 10'h200, 10'h000, 10'h004, 10'h200, 10'h000,
    10'h000, 10'h008, 10'h002, 10'h001, 10'h002, 10'h000, 10'h100, 10'h048};

  assign {dec_valid, dec_class, dec_generic_t, dec_long_disp, dec_pre_update,
    dec_long_abs, dec_long_imm, dec_is_arith, dec_is_cond_xfer,
    dec_move_src_acc, dec_move_dst_acc, dec_arith_dst_acc, dec_sr_read_move,
    dec_sr_read_bit, dec_ptr_src, dec_agu_use, dec_agu_wr, ext_data_acc,
    ext_data_waits, ext_fetch, bus_wait_control_reg} = dsc;

  psi_interlock u_dut (.*);
  psi_dec_model u_dec (.core_clk(core_clk), .rstn(rstn),
    .dec_hold(dec_hold), .dsc(dsc));

  // Clock and cycle ceiling
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      give_verdict();
    end
  end

  // Queues one descriptor and notes its expected base and stall
  task automatic put();
    logic [3:0] b;
    int s;
    if (v) begin
      s = (|(ms & (pad | pmd)) || (sb && (pa || pa2)) || (pcx && |ps));
      if (sm && (pa || pa2)) s = 2;
      for (int i = 0; i < 8; i++)
        if (au[i] && now - tw[i] < 4 && 4 - (now - tw[i]) > s)
          s = 4 - (now - tw[i]);
      s = s + (xa ? xw : 0) + (xf ? bw : 0);
      case (c)
        4'h1: b = ld ? 4'h3 : 4'h2;
        4'h2: b = 4'h6 + pu + la;
        4'h3: b = 4'h2 + pu + la;
        4'h4: b = 4'h4 + pu;
        4'h5: b = 4'h1 + pu + la + li;
        default: b = g + pu + la + li;
      endcase
      exp_q.push_back({b, 6'(s)});
      for (int i = 0; i < 8; i++) if (aw[i]) tw[i] = now + s;
      now = now + 1 + s;
      {pa2, pa, pad, pmd, pcx} = {pa, ar, ar ? ad : 2'h0, md, cx};
    end else now++;
    u_dec.q.push_back(`FLD);
    `FLD = `NEU;
  endtask

  // Waits for all issues, then two plain descriptors clear history
  task automatic sync();
    for (int k = 0; k < 5000 && exp_q.size() != 0; k++) @(negedge core_clk);
    repeat (4) @(negedge core_clk);
    now = now + 1000;
    repeat (2) put();
  endtask

  task automatic give_verdict();
    if (err_total == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Counts bubbles and checks each issue against the oldest note
  always @(negedge core_clk) begin
    if (exe_bubble === 1'b1) nb++;
    if (exe_issue === 1'b1) begin
      if (exp_q.size() == 0) `CHK("spare issue", 1'b0, 1'b1)
      else begin
        `CHK("base stall", exp_q[0], {exe_base_cycles, exe_stall_cycles})
        `CHK("bubbles", exp_q[0][5:0], 6'(nb))
        void'(exp_q.pop_front());
      end
      nb = 0;
    end
  end

  // Reset, then class table, data hazards, address hazards, waits, random
  initial begin
    {core_clk, rstn, err_total, checked, cyc, nb, now} = '0;
    foreach (tw[i]) tw[i] = -100;
    `FLD = `NEU;
    void'($urandom(64));
    repeat (20) @(negedge core_clk);
    rstn = 1'b1;
    for (int k = 0; k < 96; k++) begin
      {c, ld, pu, la, li, g} = {4'(k / 16 + 1), 4'(k), 4'(k % 13)};
      put();
    end
    sync();
    foreach (alu_t[i]) begin
      {ad, ms, md, sm, sb, cx, ps[7]} = alu_t[i];
      ar = |ad;
      put();
    end
    sync();
    for (int d = 0; d < 4; d++) begin
      aw = 8'h01;
      put();
      repeat (d) begin v = 1'b0; put(); end
      au = 8'h01;
      put();
    end
    aw = 8'h02; put(); put(); au = 8'h02; put(); au = 8'h02; put();
    {ar, ad, aw} = {1'b1, 2'h1, 8'h04}; put(); ms = 2'h1; put();
    au = 8'h04; put(); aw = 8'h08; put(); au = 8'h10; put();
    {ar, ad, aw} = {1'b1, 2'h1, 8'h20}; put(); {ms, au} = {2'h1, 8'h20}; put();
    {ar, ad} = {1'b1, 2'h1}; put(); {ms, aw} = {2'h1, 8'h40}; put();
    au = 8'h40; put();
    {ar, ad} = {1'b1, 2'h1}; put(); {ms, ar, ad} = {2'h1, 1'b1, 2'h2}; put();
    ms = 2'h2; put();
    sync();
    for (int w = 0; w < 16; w += 5) begin
      {xa, xw} = {1'b1, 4'(w)}; put(); {xf, bw} = {1'b1, 4'(w)}; put();
      {xa, xw, xf, bw} = {1'b1, 4'(15 - w), 1'b1, 4'(w)}; put();
      {ar, ad} = {1'b1, 2'h2}; put(); {ms, xa, xw} = {2'h2, 1'b1, 4'(w)}; put();
    end
    sync();
    for (int n = 0; n < 300; n++) begin
      {c, g} = {4'($urandom_range(6, 1)), 4'($urandom_range(12))};
      {ld, pu, la, li, ar, cx, sm, sb, xa, xf, ms, md, xw, bw} = 22'($urandom);
      ad = ar ? 2'($urandom) : 2'h0;
      ps = 8'($urandom) & {8{$urandom_range(3) == 0}};
      put();
    end
    sync();
    give_verdict();
  end
endmodule
